// ---- hdl/aiu_regs.svh ----
// opcode map, field positions and timing counts of the arithmetic unit
// assumes: included by the unit only; the package does not include it
`ifndef AIU_REGS_SVH
`define AIU_REGS_SVH
// ====================================================================
// instruction set size and opcode groups (upper nibble)
`define AIU_INSN_TOTAL   112
`define AIU_GRP_ADD      4'h2
`define AIU_GRP_ADD_WITH_CARRY_OP     4'h3
`define AIU_GRP_SUBTRACT_WITH_BORROW_OP     4'h9
`define AIU_OP_MUL       8'ha4
`define AIU_OP_DIV       8'h84
`define AIU_OP_DA        8'hd4
`define AIU_OP_LJMP      8'h02
`define AIU_OP_LCALL     8'h12
`define AIU_OP_UNDEF     8'ha5
`define AIU_PAGE_LOW     5'h01
// ====================================================================
// operand source (lower nibble)
`define AIU_SRC_IMM      4'h4
`define AIU_SRC_DIR      4'h5
// ====================================================================
// decimal adjust figures and bit positions
`define AIU_BCD_MAX      4'h9
`define AIU_BCD_FIX      4'h6
`define AIU_MSB          7
`define AIU_PAGE_HI      15
`define AIU_PAGE_LO      11
// ====================================================================
// machine cycle counts and instruction lengths in bytes
`define AIU_CYC_1        3'h1
`define AIU_CYC_2        3'h2
`define AIU_CYC_4        3'h4
`define AIU_LEN_1        2'h1
`define AIU_LEN_2        2'h2
`define AIU_LEN_3        2'h3
`endif

// ---- hdl/aiu_pkg.sv ----
// types shared by the arithmetic unit and its bench
// assumes: compiled before the unit
package aiu_pkg;
  // ==================================================================
  // sequencer states, gray along idle -> run
  typedef enum logic [1:0] {
    AIU_IDLE = 2'b00,
    AIU_RUN  = 2'b01
  } aiu_state_t;
  // ==================================================================
  // operation performed by the unit
  typedef enum logic [2:0] {
    AIU_NONE = 3'h0,
    AIU_ADD  = 3'h1,
    AIU_ADD_WITH_CARRY_OP = 3'h2,
    AIU_SUBTRACT_WITH_BORROW_OP = 3'h3,
    AIU_MUL  = 3'h4,
    AIU_DIV  = 3'h5,
    AIU_DA   = 3'h6
  } aiu_kind_t;
endpackage

// ---- hdl/aiu_unit.sv ----
// arithmetic instruction unit: add, subtract, multiply, divide, bcd adjust
// assumes: core hands over one opcode with its bytes per request, one
// machine cycle per MCLK, operand already fetched into OP_DATA
`timescale 1ns/1ns
`include "aiu_regs.svh"

module aiu_unit (
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                SYS_RST,
  // instruction request
  input  wire logic                OP_VALID,
  input  wire logic [7:0]          OP_CODE,
  input  wire logic [7:0]          OP_BYTE2,
  input  wire logic [7:0]          OP_BYTE3,
  input  wire logic [7:0]          OP_DATA,
  input  wire logic [15:0]         PC_NEXT,
  // register loads from the core
  input  wire logic                ACC_LOAD,
  input  wire logic [7:0]          ACC_LOAD_DATA,
  input  wire logic                B_LOAD,
  input  wire logic [7:0]          B_LOAD_DATA,
  input  wire logic                FLAG_LOAD,
  input  wire logic [2:0]          FLAG_LOAD_DATA,
  // status and results
  output logic                     OP_READY,
  output logic                     OP_DONE,
  output logic [7:0]               ACC,
  output logic [7:0]               B_OUT,
  output logic                     CARRY,
  output logic                     AUX_CARRY,
  output logic                     OVERFLOW,
  output logic [1:0]               INSN_LEN,
  output logic [2:0]               INSN_CYC,
  output logic                     INSN_UNDEF,
  output logic [15:0]              JUMP_TARGET,
  output logic                     JUMP_VALID
);
  import aiu_pkg::*;

  // ==================================================================
  // decoding helpers, used by the sequencer and the datapath
  // opcode to kind
  function automatic aiu_kind_t kind_of(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[7:4];
    kind_of = AIU_NONE;
    if (op == `AIU_OP_MUL) kind_of = AIU_MUL;
    else if (op == `AIU_OP_DIV) kind_of = AIU_DIV;
    else if (op == `AIU_OP_DA) kind_of = AIU_DA;
    else if (op[3:0] >= `AIU_SRC_IMM) begin
      if (hi == `AIU_GRP_ADD) kind_of = AIU_ADD;
      else if (hi == `AIU_GRP_ADD_WITH_CARRY_OP) kind_of = AIU_ADD_WITH_CARRY_OP;
      else if (hi == `AIU_GRP_SUBTRACT_WITH_BORROW_OP) kind_of = AIU_SUBTRACT_WITH_BORROW_OP;
    end
  endfunction

  function automatic logic [4:0] fmt_of(input logic [7:0] op);
    fmt_of = {`AIU_LEN_1, `AIU_CYC_1};
    if (op == `AIU_OP_MUL || op == `AIU_OP_DIV)
      fmt_of = {`AIU_LEN_1, `AIU_CYC_4};
    else if (op == `AIU_OP_LJMP || op == `AIU_OP_LCALL)
      fmt_of = {`AIU_LEN_3, `AIU_CYC_2};
    else if (op[4:0] == `AIU_PAGE_LOW)
      fmt_of = {`AIU_LEN_2, `AIU_CYC_2};
    else if (kind_of(op) != AIU_NONE && kind_of(op) != AIU_DA &&
             (op[3:0] == `AIU_SRC_IMM || op[3:0] == `AIU_SRC_DIR))
      fmt_of = {`AIU_LEN_2, `AIU_CYC_1};
  endfunction

  // ==================================================================
  // state
  aiu_state_t  state_reg, state_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [7:0]  op_reg, op_next;
  logic [7:0]  opnd_reg, opnd_next;
  logic [7:0]  acc_reg, acc_next;
  logic [7:0]  b_reg, b_next;
  logic        cy_reg, cy_next;
  logic        ac_reg, ac_next;
  logic        ov_reg, ov_next;
  logic [4:0]  fmt_reg, fmt_next;
  logic        undef_reg, undef_next;
  logic [15:0] tgt_reg, tgt_next;
  logic        tgtv_reg, tgtv_next;
  logic        last;
  aiu_kind_t   kind;

  // ==================================================================
  // datapath results for the latched instruction
  logic [8:0]  sum9;
  logic [4:0]  lo5;
  logic [7:0]  s8;     // low 7 bits added alone, bit 7 is the carry into the sign bit
  logic        c6;
  logic [7:0]  res_acc, res_b;
  logic        res_cy, res_ac, res_ov;
  logic [15:0] prod;
  logic [8:0]  da1, da2;

  assign kind = kind_of(op_reg);
  assign last = (state_reg == AIU_RUN) && (cnt_reg == 3'h0);

  // arithmetic of every kind; only the latched kind is committed
  always_comb begin
    logic sub;
    logic cin;
    sub     = (kind == AIU_SUBTRACT_WITH_BORROW_OP);
    cin     = (kind == AIU_ADD) ? 1'b0 : (cy_reg ^ sub);
    res_acc = acc_reg;
    res_b   = b_reg;
    res_cy  = cy_reg;
    res_ac  = ac_reg;
    res_ov  = ov_reg;
    prod    = acc_reg * b_reg;
    // shared adder, borrow as inverted carry
    lo5  = {1'b0, acc_reg[3:0]} + {1'b0, sub ? ~opnd_reg[3:0] : opnd_reg[3:0]} + {4'h0, cin};
    sum9 = {1'b0, acc_reg} + {1'b0, sub ? ~opnd_reg : opnd_reg} + {8'h00, cin};
    s8   = {1'b0, acc_reg[6:0]} + {1'b0, sub ? ~opnd_reg[6:0] : opnd_reg[6:0]} + {7'h00, cin};
    c6   = s8[7];
    da1 = {1'b0, acc_reg};
    if (acc_reg[3:0] > `AIU_BCD_MAX || ac_reg)
      da1 = {1'b0, acc_reg} + {5'h00, `AIU_BCD_FIX};
    // high nibble correction including low carry
    da2 = da1;
    if (da1[8] || da1[7:4] > `AIU_BCD_MAX || cy_reg)
      da2 = da1 + {1'b0, `AIU_BCD_FIX, 4'h0};
    case (kind)
      AIU_ADD, AIU_ADD_WITH_CARRY_OP, AIU_SUBTRACT_WITH_BORROW_OP: begin
        res_acc = sum9[7:0];
        // carry or borrow out of bit7
        res_cy  = sum9[`AIU_MSB + 1] ^ sub;
        res_ac  = lo5[4] ^ sub;
        res_ov  = sum9[`AIU_MSB + 1] ^ c6;
      end
      AIU_MUL: begin
        // product split across b and acc
        res_b   = prod[15:8];
        res_acc = prod[7:0];
        res_cy  = 1'b0;
        res_ov  = (prod[15:8] != 8'h00);
      end
      AIU_DIV: begin
        // divide by zero leaves operands, flags overflow
        res_cy = 1'b0;
        res_ov = (b_reg == 8'h00);
        if (b_reg != 8'h00) begin
          res_acc = acc_reg / b_reg;
          res_b   = acc_reg % b_reg;
        end
      end
      AIU_DA: begin
        res_acc = da2[7:0];
        // carry only ever set here, never cleared
        res_cy  = cy_reg | da2[8] | da1[8];
      end
      default: begin
        res_acc = acc_reg;
      end
    endcase
  end

  // ==================================================================
  // sequencer and register next values
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    op_next    = op_reg;
    opnd_next  = opnd_reg;
    acc_next   = acc_reg;
    b_next     = b_reg;
    cy_next    = cy_reg;
    ac_next    = ac_reg;
    ov_next    = ov_reg;
    fmt_next   = fmt_reg;
    undef_next = undef_reg;
    tgt_next   = tgt_reg;
    tgtv_next  = tgtv_reg;
    case (state_reg)
      AIU_IDLE: begin
        // core loads only while idle, so no commit can collide
        if (ACC_LOAD) acc_next = ACC_LOAD_DATA;
        if (B_LOAD) b_next = B_LOAD_DATA;
        if (FLAG_LOAD) {cy_next, ac_next, ov_next} = FLAG_LOAD_DATA;
        if (OP_VALID) begin
          state_next = AIU_RUN;
          op_next    = OP_CODE;
          // immediate taken whole from the second byte
          opnd_next  = (OP_CODE[3:0] == `AIU_SRC_IMM) ? OP_BYTE2[7:0] : OP_DATA;
          // latch format, run for its cycle count
          fmt_next   = fmt_of(OP_CODE);
          cnt_next   = 3'(fmt_of(OP_CODE) - 5'h01);
          undef_next = (OP_CODE == `AIU_OP_UNDEF);
          tgtv_next  = 1'b1;
          if (OP_CODE == `AIU_OP_LJMP || OP_CODE == `AIU_OP_LCALL)
            tgt_next = {OP_BYTE2, OP_BYTE3};
          else if (OP_CODE[4:0] == `AIU_PAGE_LOW)
            tgt_next = {PC_NEXT[`AIU_PAGE_HI:`AIU_PAGE_LO], OP_CODE[7:5], OP_BYTE2};
          else
            tgtv_next = 1'b0;
        end
      end
      AIU_RUN: begin
        cnt_next = cnt_reg - 3'h1;
        if (cnt_reg == 3'h0) begin
          // commit on the last machine cycle
          state_next = AIU_IDLE;
          acc_next   = res_acc;
          b_next     = res_b;
          cy_next    = res_cy;
          ac_next    = res_ac;
          ov_next    = res_ov;
        end
      end
      default: state_next = AIU_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= AIU_IDLE;
      cnt_reg   <= 3'h0;
      op_reg    <= 8'h00;
      opnd_reg  <= 8'h00;
      acc_reg   <= 8'h00;
      b_reg     <= 8'h00;
      cy_reg    <= 1'b0;
      ac_reg    <= 1'b0;
      ov_reg    <= 1'b0;
      fmt_reg   <= 5'h00;
      undef_reg <= 1'b0;
      tgt_reg   <= 16'h0000;
      tgtv_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      op_reg    <= op_next;
      opnd_reg  <= opnd_next;
      acc_reg   <= acc_next;
      b_reg     <= b_next;
      cy_reg    <= cy_next;
      ac_reg    <= ac_next;
      ov_reg    <= ov_next;
      fmt_reg   <= fmt_next;
      undef_reg <= undef_next;
      tgt_reg   <= tgt_next;
      tgtv_reg  <= tgtv_next;
    end
  end

  // ==================================================================
  // outputs
  assign OP_READY    = (state_reg == AIU_IDLE);
  assign OP_DONE     = last;
  assign ACC         = acc_reg;
  assign B_OUT       = b_reg;
  assign CARRY       = cy_reg;
  assign AUX_CARRY   = ac_reg;
  assign OVERFLOW    = ov_reg;
  assign INSN_LEN    = fmt_reg[4:3];
  assign INSN_CYC    = fmt_reg[2:0];
  assign INSN_UNDEF  = undef_reg;
  assign JUMP_TARGET = tgt_reg;
  assign JUMP_VALID  = tgtv_reg;

  // ==================================================================
  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_take_mul;
    OP_READY && OP_VALID && OP_CODE == `AIU_OP_MUL;
  endsequence
  sequence s_four_run;
    !OP_DONE [*3] ##1 OP_DONE;
  endsequence

  a_mul_timing: assert property (s_take_mul |=> s_four_run)
    else $error("multiply did not finish in four cycles");
  a_mul_product: assert property (last && kind == AIU_MUL |=>
    {B_OUT, ACC} == $past(acc_reg) * $past(b_reg))
    else $error("multiply product wrong");
  a_div_result: assert property (last && kind == AIU_DIV && b_reg != 8'h00 |=>
    ACC == $past(acc_reg) / $past(b_reg) && B_OUT == $past(acc_reg) % $past(b_reg))
    else $error("divide result wrong");
  a_add_with_carry_op_sum: assert property (last && kind == AIU_ADD_WITH_CARRY_OP |=>
    {CARRY, ACC} == {1'b0, $past(acc_reg)} + $past(opnd_reg) + $past(cy_reg))
    else $error("add with carry result wrong");
  a_subtract_with_borrow_op_diff: assert property (last && kind == AIU_SUBTRACT_WITH_BORROW_OP |=>
    {CARRY, ACC} == {1'b0, $past(acc_reg)} - $past(opnd_reg) - $past(cy_reg))
    else $error("subtract with borrow result wrong");
  a_carry_bit7: assert property (last && kind == AIU_ADD |=>
    CARRY == ({1'b0, $past(acc_reg)} + $past(opnd_reg) > 9'h0ff))
    else $error("carry not taken from bit7");
  a_da_low_fix: assert property (last && kind == AIU_DA && !cy_reg && !ac_reg &&
    acc_reg[3:0] <= `AIU_BCD_MAX && acc_reg[7:4] <= `AIU_BCD_MAX |=>
    ACC == $past(acc_reg) && !CARRY)
    else $error("decimal adjust changed a valid bcd byte");
  a_da_high_fix: assert property (last && kind == AIU_DA && cy_reg |=>
    CARRY && ACC[7:4] == $past(da1[7:4]) + `AIU_BCD_FIX)
    else $error("decimal adjust high nibble wrong");
  a_da_carry_set: assert property (last && kind == AIU_DA && da2[8] |=> CARRY)
    else $error("decimal adjust carry not set");
  a_long_target: assert property (OP_READY && OP_VALID && OP_CODE == `AIU_OP_LJMP |=>
    JUMP_VALID && JUMP_TARGET == {$past(OP_BYTE2), $past(OP_BYTE3)} &&
    INSN_LEN == `AIU_LEN_3)
    else $error("long jump target wrong");
  a_imm_operand: assert property (OP_READY && OP_VALID &&
    OP_CODE[3:0] == `AIU_SRC_IMM && kind_of(OP_CODE) inside {AIU_ADD, AIU_ADD_WITH_CARRY_OP, AIU_SUBTRACT_WITH_BORROW_OP}
    |=> opnd_reg == $past(OP_BYTE2) && INSN_LEN == `AIU_LEN_2)
    else $error("immediate operand not from second byte");
  a_undef_code: assert property (OP_READY && OP_VALID |=>
    INSN_UNDEF == ($past(OP_CODE) == `AIU_OP_UNDEF))
    else $error("undefined opcode flag wrong");
  a_cycle_class: assert property (OP_READY && OP_VALID |=>
    INSN_CYC == `AIU_CYC_1 || INSN_CYC == `AIU_CYC_2 || INSN_CYC == `AIU_CYC_4)
    else $error("cycle class outside 1, 2, 4");
endmodule

// ---- sim/aiu_unit_tb.sv ----
// bench for the arithmetic unit: corner and random instructions, self-checking
// assumes: aiu_pkg and aiu_unit compiled first; the bench drives every pin itself
`timescale 1ns/1ns
module aiu_unit_tb;
  import aiu_pkg::*;
  // ==================================================================
  // pins, reference state and counters
  logic        MCLK, SYS_RST, OP_VALID, ACC_LOAD, B_LOAD, FLAG_LOAD;
  logic [7:0]  OP_CODE, OP_BYTE2, OP_BYTE3, OP_DATA, ACC_LOAD_DATA, B_LOAD_DATA;
  logic [15:0] PC_NEXT, JUMP_TARGET;
  logic [2:0]  FLAG_LOAD_DATA, INSN_CYC;
  logic [1:0]  INSN_LEN;
  logic        OP_READY, OP_DONE, CARRY, AUX_CARRY, OVERFLOW, INSN_UNDEF, JUMP_VALID;
  logic [7:0]  ACC, B_OUT, m_acc, m_b, op;
  logic        m_c, m_ac, m_ov;
  logic [7:0]  ops [6] = '{8'h20, 8'h30, 8'h90, 8'ha4, 8'h84, 8'hd4};
  logic [7:0]  jops [8] = '{8'h02, 8'h12, 8'h01, 8'he1, 8'h31, 8'ha5, 8'h23, 8'he4};
  int          fails, checks, k;

  aiu_unit u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_BYTE2(OP_BYTE2), .OP_BYTE3(OP_BYTE3), .OP_DATA(OP_DATA), .PC_NEXT(PC_NEXT),
    .ACC_LOAD(ACC_LOAD), .ACC_LOAD_DATA(ACC_LOAD_DATA), .B_LOAD(B_LOAD),
    .B_LOAD_DATA(B_LOAD_DATA), .FLAG_LOAD(FLAG_LOAD), .FLAG_LOAD_DATA(FLAG_LOAD_DATA),
    .OP_READY(OP_READY), .OP_DONE(OP_DONE), .ACC(ACC), .B_OUT(B_OUT), .CARRY(CARRY),
    .AUX_CARRY(AUX_CARRY), .OVERFLOW(OVERFLOW), .INSN_LEN(INSN_LEN), .INSN_CYC(INSN_CYC),
    .INSN_UNDEF(INSN_UNDEF), .JUMP_TARGET(JUMP_TARGET), .JUMP_VALID(JUMP_VALID));

  // ==================================================================
  // free-running machine-cycle clock
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // ==================================================================
  // compare, report and timing helpers
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // inputs move 1 ns after the rising edge so no race with the sampling edge
  task automatic tick;
    @(posedge MCLK);
    #1;
  endtask

  // ==================================================================
  // expected length and cycle class of an opcode, {len, cyc}
  function automatic logic [4:0] fmt(input logic [7:0] o);
    if (o == 8'ha4 || o == 8'h84) return {2'h1, 3'h4};
    if (o == 8'h02 || o == 8'h12) return {2'h3, 3'h2};
    if (o[4:0] == 5'h01) return {2'h2, 3'h2};
    if ((o[7:4] == 4'h2 || o[7:4] == 4'h3 || o[7:4] == 4'h9) && o[3:1] == 3'h2)
      return {2'h2, 3'h1};
    return {2'h1, 3'h1};
  endfunction

  // reference arithmetic: updates the bench copy of acc, b and flags
  task automatic model(input logic [7:0] o, input logic [7:0] v);
    logic [8:0]  s;
    logic [4:0]  l;
    logic [7:0]  m;
    logic [15:0] p;
    logic        ci;
    ci = (o[7:4] == 4'h3 || o[7:4] == 4'h9) ? m_c : 1'b0;
    if (o == 8'ha4) begin
      p = m_acc * m_b;
      {m_b, m_acc} = p;
      m_c = 1'b0;
      m_ov = |p[15:8];
    end else if (o == 8'h84) begin
      m_c = 1'b0;
      m_ov = (m_b == 8'h00);
      if (m_b != 8'h00) {m_acc, m_b} = {m_acc / m_b, m_acc % m_b};
    end else if (o == 8'hd4) begin
      s = {1'b0, m_acc};
      if (s[3:0] > 4'h9 || m_ac) s = s + 9'h006;
      if (s[8:4] > 5'h09 || m_c) s = s + 9'h060;
      if (s[8]) m_c = 1'b1;
      m_acc = s[7:0];
    end else if ((o[7:4] == 4'h2 || o[7:4] == 4'h3) && o[3:0] >= 4'h4) begin
      s = m_acc + v + ci;
      l = m_acc[3:0] + v[3:0] + ci;
      m = m_acc[6:0] + v[6:0] + ci;
      {m_c, m_ac, m_ov, m_acc} = {s[8], l[4], m[7] ^ s[8], s[7:0]};
    end else if (o[7:4] == 4'h9 && o[3:0] >= 4'h4) begin
      s = {1'b0, m_acc} - v - ci;
      l = {1'b0, m_acc[3:0]} - v[3:0] - ci;
      m = {1'b0, m_acc[6:0]} - v[6:0] - ci;
      {m_c, m_ac, m_ov, m_acc} = {s[8], l[4], m[7] ^ s[8], s[7:0]};
    end
  endtask

  // ==================================================================
  // register loads while idle, taken at the next edge
  task automatic load(input logic [7:0] a, input logic [7:0] bv, input logic [2:0] f);
    {ACC_LOAD, B_LOAD, FLAG_LOAD} = 3'b111;
    {ACC_LOAD_DATA, B_LOAD_DATA, FLAG_LOAD_DATA} = {a, bv, f};
    tick;
    {ACC_LOAD, B_LOAD, FLAG_LOAD} = 3'b000;
    {m_acc, m_b, m_c, m_ac, m_ov} = {a, bv, f};
  endtask

  // one instruction: take, count cycles to done, then compare the commit
  task automatic run(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3,
                     input logic [7:0] dat);
    int         n;
    logic       jmp;
    logic [4:0] f;
    f = fmt(o);
    jmp = (o == 8'h02 || o == 8'h12 || o[4:0] == 5'h01);
    chk_flag(OP_READY, 1'b1, "ready idle");
    {OP_VALID, OP_CODE, OP_BYTE2, OP_BYTE3, OP_DATA} = {1'b1, o, b2, b3, dat};
    PC_NEXT = 16'($urandom);
    tick;
    OP_VALID = 1'b0;
    n = 1;
    while (OP_DONE !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    if (n >= 20) begin
      fails++;
      results;
    end
    chk_val(16'(n), 16'(f[2:0]), "cycles");
    chk_val(16'(INSN_LEN), 16'(f[4:3]), "length");
    chk_val(16'(INSN_CYC), 16'(f[2:0]), "cycle class");
    chk_flag(INSN_UNDEF, o == 8'ha5, "undefined");
    chk_flag(JUMP_VALID, jmp, "jump valid");
    if (o[4:0] == 5'h01) chk_val(JUMP_TARGET, {PC_NEXT[15:11], o[7:5], b2}, "page");
    else if (jmp) chk_val(JUMP_TARGET, {b2, b3}, "long target");
    model(o, (o[3:0] == 4'h4) ? b2 : dat);
    tick;
    chk_val(16'(ACC), 16'(m_acc), "acc");
    chk_val(16'(B_OUT), 16'(m_b), "b");
    chk_flag(CARRY, m_c, "carry");
    chk_flag(AUX_CARRY, m_ac, "aux");
    chk_flag(OVERFLOW, m_ov, "overflow");
  endtask

  // ==================================================================
  // main sequence: reset, corners, formats, then random traffic
  initial begin
    {OP_VALID, ACC_LOAD, B_LOAD, FLAG_LOAD, FLAG_LOAD_DATA} = 7'h00;
    {OP_CODE, OP_BYTE2, OP_BYTE3, OP_DATA, ACC_LOAD_DATA, B_LOAD_DATA} = 48'h0;
    PC_NEXT = 16'h0000;
    SYS_RST = 1'b1;
    fails = 0;
    checks = 0;
    void'($urandom(32'hf9e1));
    tick;
    tick;
    SYS_RST = 1'b0;
    {m_acc, m_b, m_c, m_ac, m_ov} = 19'h0;
    chk_val({ACC, B_OUT}, 16'h0000, "reset regs");
    chk_flag(OP_DONE, 1'b0, "reset done");
    load(8'h7f, 8'h00, 3'b000);
    run(8'h34, 8'h01, 8'h00, 8'h55);
    load(8'h80, 8'h00, 3'b100);
    run(8'h98, 8'h00, 8'h00, 8'h00);
    load(8'hff, 8'hff, 3'b000);
    run(8'ha4, 8'h00, 8'h00, 8'h00);
    load(8'h12, 8'h00, 3'b000);
    run(8'h84, 8'h00, 8'h00, 8'h00);
    load(8'hfb, 8'h07, 3'b010);
    run(8'h84, 8'h00, 8'h00, 8'h00);
    load(8'h99, 8'h00, 3'b000);
    run(8'h24, 8'h01, 8'h00, 8'h33);
    run(8'hd4, 8'h00, 8'h00, 8'h00);
    load(8'h00, 8'h00, 3'b100);
    run(8'hd4, 8'h00, 8'h00, 8'h00);
    foreach (jops[i]) run(jops[i], 8'($urandom), 8'($urandom), 8'($urandom));
    // random arithmetic with occasional reloads of acc, b and flags
    for (int i = 0; i < 120; i++) begin
      if ($urandom_range(0, 2) == 0) load(8'($urandom), 8'($urandom), 3'($urandom));
      k = $urandom_range(0, 5);
      op = ops[k];
      if (k < 3) op[3:0] = 4'($urandom_range(4, 15));
      run(op, 8'($urandom), 8'($urandom), 8'($urandom));
    end
    results;
  end
endmodule
